// File: verilog/pin_ctrl_pkg.sv
// Purpose: shared constants and carriers for the pin output control block
// Assumes: classic Wishbone, 32-bit data, word-aligned registers
// Notes: offsets below are byte addresses
package pin_ctrl_pkg;
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] GROUP_OUT_OFS = 8'h04;
    localparam logic [7:0] GROUP_IN_OFS = 8'h08;
    localparam int DRIVE_TYPE_POS = 8;
    localparam int DIR_POS = 9;
    localparam int OUT_SRC_POS = 10;
    localparam int POLARITY_POS = 11;
    localparam int MUX_LO_POS = 12;
    localparam int OUT_DATA_POS = 16;
    localparam int PIN_IN_POS = 24;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [31:0] WRITE_MASK = 32'h0001_3f00;
    localparam logic [1:0] MUX_GPIO = 2'h0;

    typedef struct packed {
        logic [1:0] muxSel;
        logic polarity;
        logic outSrc;
        logic dir;
        logic openDrain;
        logic outData;
        logic groupOut;
    } pin_cfg_t;

    // Signals from the three alternate functions
    typedef struct packed {
        logic [2:0] out;
        logic [2:0] oe;
    } alt_fn_t;

    typedef struct packed {
        logic o;
        logic oe;
    } pad_drive_t;
endpackage

// File: verilog/pin_output_control.sv
// Purpose: per-pin output polarity, source select, direction and drive type
// Assumes: single mclk domain; pad input is asynchronous and synchronised here
// Notes: registers at 0x00 control, 0x04 grouped output bit, 0x08 input bit
// What this block does
// - Polarity inverts alternate function outputs
// - Polarity inverts interrupt detection sense too, in alternate modes only
// - GPIO mode ignores polarity, no inversion
// - Input register reports pin level uninverted
// - Source 0: single data bit drives pin
// - Source 1: grouped output bit drives pin
// - Direction bit acts only in GPIO mode
// - Alternate function controls buffer direction itself
// - Drive type 0 push-pull, 1 open-drain
// - Drive type applies to every function
// - Selector 00 GPIO, else alternate 1-3
// - Data bit reads last accepted value; writes are ignored while source 1 is selected
`timescale 1ns/1ps
module pin_output_control
    import pin_ctrl_pkg::*;
(
    input wire logic mclk,
    input wire logic nrst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire pin_ctrl_pkg::alt_fn_t altFn,
    input wire logic padIn,
    output logic padOut,
    output logic padOe,
    output logic detectLevel
);
    import pin_ctrl_pkg::*;

    pin_cfg_t cfg_q;
    logic ack_q;
    logic [2:0] padSync_q;
    logic padLevel_q;
    logic [31:0] rdData_d;
    logic [31:0] rdData_q;
    logic access;
    logic wrStrobe;
    logic [31:0] ctrlRead;
    logic [31:0] wMask;
    logic [31:0] ctrlNew;
    logic srcBit;
    logic rawOut;
    logic rawOe;
    pad_drive_t drive;

    assign access = wb_cyc_i && wb_stb_i && !ack_q;
    // Write lands at the ack edge, while the master still holds the request
    assign wrStrobe = wb_cyc_i && wb_stb_i && ack_q && wb_we_i;

    // Byte lanes expand to a bit mask
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_lane
            assign wMask[gi*8 +: 8] = {8{wb_sel_i[gi]}};
        end
    endgenerate

    assign ctrlNew = wb_dat_i & wMask & WRITE_MASK;

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= access;
        end
    end

    // Control fields; only the lanes enabled by sel change
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            cfg_q.muxSel <= CTRL_RESET[MUX_LO_POS +: 2];
            cfg_q.polarity <= CTRL_RESET[POLARITY_POS];
            cfg_q.outSrc <= CTRL_RESET[OUT_SRC_POS];
            cfg_q.dir <= CTRL_RESET[DIR_POS];
            cfg_q.openDrain <= CTRL_RESET[DRIVE_TYPE_POS];
        end else if (wrStrobe && wb_adr_i == CTRL_OFS && wb_sel_i[1]) begin
            cfg_q.muxSel <= ctrlNew[MUX_LO_POS +: 2];
            cfg_q.polarity <= ctrlNew[POLARITY_POS];
            cfg_q.outSrc <= ctrlNew[OUT_SRC_POS];
            cfg_q.dir <= ctrlNew[DIR_POS];
            cfg_q.openDrain <= ctrlNew[DRIVE_TYPE_POS];
        end
    end

    // each data bit writable only when it is the source
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            cfg_q.outData <= CTRL_RESET[OUT_DATA_POS];
        end else if (wrStrobe && wb_adr_i == CTRL_OFS && wb_sel_i[2] && !cfg_q.outSrc) begin
            cfg_q.outData <= wb_dat_i[OUT_DATA_POS];
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            cfg_q.groupOut <= 1'b0;
        end else if (wrStrobe && wb_adr_i == GROUP_OUT_OFS && wb_sel_i[0] && cfg_q.outSrc) begin
            cfg_q.groupOut <= wb_dat_i[0];
        end
    end

    // Three stages; a change counts when the last two agree
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            padSync_q <= 3'h0;
            padLevel_q <= 1'b0;
        end else begin
            padSync_q <= {padSync_q[1:0], padIn};
            if (padSync_q[2] == padSync_q[1]) begin
                padLevel_q <= padSync_q[2];
            end
        end
    end

    always_comb begin
        ctrlRead = 32'h0;
        ctrlRead[MUX_LO_POS +: 2] = cfg_q.muxSel;
        ctrlRead[POLARITY_POS] = cfg_q.polarity;
        ctrlRead[OUT_SRC_POS] = cfg_q.outSrc;
        ctrlRead[DIR_POS] = cfg_q.dir;
        ctrlRead[DRIVE_TYPE_POS] = cfg_q.openDrain;
        ctrlRead[OUT_DATA_POS] = cfg_q.outData;
        ctrlRead[PIN_IN_POS] = padLevel_q;
    end

    // Unmapped addresses read zero and still acknowledge
    always_comb begin
        if (wb_adr_i == CTRL_OFS) begin
            rdData_d = ctrlRead;
        end else if (wb_adr_i == GROUP_OUT_OFS) begin
            rdData_d = {31'h0, cfg_q.groupOut};
        end else if (wb_adr_i == GROUP_IN_OFS) begin
            rdData_d = {31'h0, padLevel_q};
        end else begin
            rdData_d = 32'h0;
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            rdData_q <= 32'h0;
        end else if (access && !wb_we_i) begin
            rdData_q <= rdData_d;
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdData_q;

    assign srcBit = cfg_q.outSrc ? cfg_q.groupOut : cfg_q.outData;

    always_comb begin
        // GPIO mode, no inversion, direction bit rules
        if (cfg_q.muxSel == MUX_GPIO) begin
            rawOut = srcBit;
            rawOe = cfg_q.dir;
        end else begin
            // alternate output with polarity, its own enable
            rawOut = altFn.out[cfg_q.muxSel - 2'h1] ^ cfg_q.polarity;
            rawOe = altFn.oe[cfg_q.muxSel - 2'h1];
        end
        drive.o = rawOut;
        // open-drain only pulls low, for every function
        drive.oe = cfg_q.openDrain ? (rawOe && !rawOut) : rawOe;
    end

    assign padOut = cfg_q.openDrain ? 1'b0 : drive.o;
    assign padOe = drive.oe;

    // detection sense follows polarity only for alternate functions
    assign detectLevel = padLevel_q ^ (cfg_q.polarity && cfg_q.muxSel != MUX_GPIO);

    a_gpio_no_invert: assert property (@(posedge mclk) disable iff (!nrst)
        (cfg_q.muxSel == MUX_GPIO && cfg_q.dir && !cfg_q.openDrain) |-> (padOut == srcBit && padOe))
        else $error("gpio output inverted or disabled");

    a_alt_invert: assert property (@(posedge mclk) disable iff (!nrst)
        (cfg_q.muxSel != MUX_GPIO && !cfg_q.openDrain)
        |-> (padOut == (altFn.out[cfg_q.muxSel - 2'h1] ^ cfg_q.polarity)))
        else $error("alternate output polarity wrong");

    a_detect_sense: assert property (@(posedge mclk) disable iff (!nrst)
        detectLevel == (padLevel_q ^ (cfg_q.polarity && cfg_q.muxSel != 2'h0)))
        else $error("detect sense wrong");

    a_input_raw: assert property (@(posedge mclk) disable iff (!nrst)
        (padSync_q[2] == padSync_q[1]) |=> (padLevel_q == $past(padSync_q[2])))
        else $error("input level not raw");

    a_data_locked: assert property (@(posedge mclk) disable iff (!nrst)
        cfg_q.outSrc && $past(cfg_q.outSrc) |-> $stable(cfg_q.outData))
        else $error("single data bit changed while read-only");

    a_group_locked: assert property (@(posedge mclk) disable iff (!nrst)
        !cfg_q.outSrc && $past(!cfg_q.outSrc) |-> $stable(cfg_q.groupOut))
        else $error("grouped bit changed while read-only");

    a_dir_alt: assert property (@(posedge mclk) disable iff (!nrst)
        (cfg_q.muxSel != MUX_GPIO && !cfg_q.openDrain) |-> (padOe == altFn.oe[cfg_q.muxSel - 2'h1]))
        else $error("alternate direction not followed");

    a_gpio_input: assert property (@(posedge mclk) disable iff (!nrst)
        (cfg_q.muxSel == MUX_GPIO && !cfg_q.dir) |-> !padOe)
        else $error("input pin driven");

    a_open_drain: assert property (@(posedge mclk) disable iff (!nrst)
        cfg_q.openDrain |-> (!padOut && (padOe == (rawOe && !rawOut))))
        else $error("open-drain drove high");

    a_ack_pulse: assert property (@(posedge mclk) disable iff (!nrst)
        (access && !wb_we_i && wb_adr_i == CTRL_OFS)
        |=> (wb_ack_o && wb_dat_o[OUT_DATA_POS] == $past(cfg_q.outData)))
        else $error("read of data bit wrong");
endmodule

// File: bench/testbench.sv
// Purpose: self-checking bench for the pin output control block
// Assumes: one-cycle registered ack, pad outputs settle combinationally after a write
// Notes: pad input passes a synchroniser, so reads of it wait a few cycles
`timescale 1ns/1ps
module testbench;
    import pin_ctrl_pkg::*;
    logic mclk = 1'b0;
    logic nrst = 1'b0;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    alt_fn_t altFn = '{out: 3'h5, oe: 3'h3};
    logic padIn = 1'b0;
    logic padOut;
    logic padOe;
    logic detectLevel;
    int failures = 0;
    int checks = 0;

    pin_output_control uut (.mclk(mclk), .nrst(nrst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .altFn(altFn), .padIn(padIn), .padOut(padOut),
        .padOe(padOe), .detectLevel(detectLevel));

    always #50 mclk = ~mclk;

    task automatic end_sim();
        if (failures == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Entered just after a rising edge; leaves one idle cycle behind
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        int n;
        n = 0;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_sel_i <= 4'hf;
        wb_dat_i <= d;
        do begin
            @(posedge mclk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        if (n >= 50)
            failures++;
        r = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
        @(posedge mclk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        wb(1'b1, a, d, r);
    endtask

    task automatic rd(input string name, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        wb(1'b0, a, 32'h0, r);
        chk(name, r, exp);
    endtask

    task automatic pad(input logic o, input logic oe);
        chk("pad", {30'h0, padOut, padOe}, {30'h0, o, oe});
    endtask

    function automatic logic [31:0] cw(input logic [1:0] m, input logic p, input logic s,
        input logic dr, input logic od, input logic dt);
        cw = 32'h0;
        cw[MUX_LO_POS +: 2] = m;
        cw[POLARITY_POS] = p;
        cw[OUT_SRC_POS] = s;
        cw[DIR_POS] = dr;
        cw[DRIVE_TYPE_POS] = od;
        cw[OUT_DATA_POS] = dt;
    endfunction

    initial begin
        repeat (5000) @(posedge mclk);
        failures++;
        end_sim();
    end

    initial begin
        repeat (20) @(posedge mclk);
        nrst <= 1'b1;
        @(posedge mclk);
        rd("ctrl", CTRL_OFS, CTRL_RESET);
        pad(1'b0, 1'b0);
        wr(CTRL_OFS, cw(2'h0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1));
        pad(1'b1, 1'b1);
        rd("ctrl", CTRL_OFS, cw(2'h0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1));
        wr(GROUP_OUT_OFS, 32'h1);
        rd("group", GROUP_OUT_OFS, 32'h0);
        wr(CTRL_OFS, cw(2'h0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0));
        wr(GROUP_OUT_OFS, 32'h1);
        wr(CTRL_OFS, cw(2'h0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1));
        pad(1'b1, 1'b1);
        rd("ctrl", CTRL_OFS, cw(2'h0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0));
        wr(GROUP_OUT_OFS, 32'h0);
        pad(1'b0, 1'b1);
        wr(CTRL_OFS, cw(2'h0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0));
        pad(1'b0, 1'b0);
        for (int m = 1; m < 4; m++) begin
            for (int p = 0; p < 2; p++) begin
                wr(CTRL_OFS, cw(m[1:0], p[0], 1'b1, 1'b0, 1'b0, 1'b0));
                pad(altFn.out[m-1] ^ p[0], altFn.oe[m-1]);
            end
        end
        wr(CTRL_OFS, cw(2'h0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0));
        pad(1'b0, 1'b1);
        wr(CTRL_OFS, cw(2'h0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1));
        pad(1'b0, 1'b0);
        for (int m = 1; m < 4; m++) begin
            wr(CTRL_OFS, cw(m[1:0], 1'b0, 1'b0, 1'b0, 1'b1, 1'b1));
            pad(1'b0, altFn.oe[m-1] & ~altFn.out[m-1]);
        end
        padIn <= 1'b1;
        wr(CTRL_OFS, cw(2'h1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0));
        repeat (8) @(posedge mclk);
        rd("gin", GROUP_IN_OFS, 32'h1);
        rd("ctrl", CTRL_OFS, cw(2'h1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0) | 32'h0100_0000);
        chk("detect", {31'h0, detectLevel}, 32'h0);
        wr(CTRL_OFS, cw(2'h0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0));
        chk("detect", {31'h0, detectLevel}, 32'h1);
        wr(8'h0c, 32'hffff_ffff);
        rd("unmapped", 8'h0c, 32'h0);
        end_sim();
    end
endmodule
